// ==== design/bcx_regs.svh ====
// register offsets, field positions, reset values and counts for the
// bus clock output and external interrupt control block.
// assumes a 32-bit apb with word-aligned registers.
`ifndef BCX_REGS_SVH
`define BCX_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define BCX_OFF_CLK_CTL 12'h000
`define BCX_OFF_INT_CTL 12'h004
`define BCX_OFF_STATUS 12'h008
`define BCX_OFF_ENABLE 12'h00c
`define BCX_OFF_CLEAR 12'h010
`define BCX_OFF_STATE 12'h014

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BCX_X2_DIS_BIT 6
`define BCX_DIV_LSB 0
`define BCX_DIV_MSB 1
`define BCX_EDGE_BIT 7
`define BCX_CONNECT_BIT 6
`define BCX_EV_EDGE 0
`define BCX_EV_REQ 1
`define BCX_EV_REFUSED 2
`define BCX_NUM_EV 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BCX_RST_CLK_CTL 8'h00
`define BCX_RST_INT_CTL 8'h40

// ------------------------------------------------------------
// counts: reference cycles per bus clock period and counter width
// ------------------------------------------------------------
`define BCX_REF_PER_BUS 4
`define BCX_CNT_W 5

`endif

// ==== design/bcx_pkg.sv ====
// types shared by the clock output and external interrupt block.
// assumes bcx_regs.svh supplies the numeric constants.
package bcx_pkg;
  typedef logic [11:0] bcx_addr_t;
  typedef logic [31:0] bcx_data_t;
  typedef logic [1:0] bcx_div_t;
  typedef enum logic [1:0] {
    BCX_MODE_NORMAL,
    BCX_MODE_SPECIAL,
    BCX_MODE_EMULATION,
    BCX_MODE_EMUL_SPECIAL
  } bcx_mode_t;
endpackage : bcx_pkg

// ==== design/bcx_clk_if.sv ====
// configuration and pin levels between the register core and the
// clock output generator; both ends run on ref_clk.
interface bcx_clk_if;
  logic x2_enable;
  logic [1:0] div_sel;
  logic emulation;
  logic x2_pin;
  logic free_pin;
  modport ctl (output x2_enable, output div_sel, output emulation,
               input x2_pin, input free_pin);
  modport gen (input x2_enable, input div_sel, input emulation,
               output x2_pin, output free_pin);
endinterface : bcx_clk_if

// ==== design/bcx_clk_gen.sv ====
// clock output generator: double-rate and divided free-running clocks.
// assumes ref_clk runs at four times the bus clock rate.
`include "bcx_regs.svh"
module bcx_clk_gen (
  input wire logic ref_clk,
  input wire logic resetn,
  bcx_clk_if.gen cif
);
  import bcx_pkg::*;

  localparam logic [`BCX_CNT_W-1:0] REF_PER_BUS = `BCX_CNT_W'(`BCX_REF_PER_BUS);

  logic [`BCX_CNT_W-1:0] cnt_q;
  logic [`BCX_CNT_W-1:0] period;
  logic [`BCX_CNT_W-1:0] half;
  logic x2_q;
  logic free_q;
  logic [2:0] ratio;

  // emulation bypasses the divider: ratio one
  always_comb begin
    ratio = cif.emulation ? 3'h1 : {1'b0, cif.div_sel} + 3'h1;
    period = `BCX_CNT_W'(REF_PER_BUS * ratio);
    half = `BCX_CNT_W'(period >> 1);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (cnt_q >= period - `BCX_CNT_W'(1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `BCX_CNT_W'(1);
    end
  end

  // one toggle per ref cycle gives twice the bus clock rate
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      x2_q <= 1'b0;
    end else if (cif.x2_enable) begin
      x2_q <= ~x2_q;
    end else begin
      x2_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      free_q <= 1'b0;
    end else begin
      free_q <= (cnt_q < half);
    end
  end

  assign cif.x2_pin = x2_q;
  assign cif.free_pin = free_q;
endmodule : bcx_clk_gen

// ==== design/bcx_top.sv ====
// top of the bus clock output and external interrupt control block.
// assumes an apb master on ref_clk and asynchronous mode and
// interrupt pins.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`include "bcx_regs.svh"
module bcx_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bcx_pkg::bcx_addr_t paddr,
  input wire bcx_pkg::bcx_data_t pwdata,
  output bcx_pkg::bcx_data_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_special_pin,
  input wire logic mode_emulation_pin,
  input wire logic ext_int_pin_n,
  input wire logic ext_int_ack,
  output logic ext_int_req,
  output logic double_rate_clock_pin,
  output logic free_running_clock_pin,
  output logic irq
);
  import bcx_pkg::*;

  localparam int NEV = `BCX_NUM_EV;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic reg_hit(input bcx_addr_t a, input bcx_addr_t off);
    reg_hit = (a == off);
  endfunction : reg_hit

  logic access;
  logic wr;
  logic rd;
  logic hit_clk;
  logic hit_int;
  logic hit_status;
  logic hit_enable;
  logic hit_clear;
  logic hit_state;
  logic mapped;

  always_comb begin
    access = psel && penable;
    wr = access && pwrite;
    rd = access && !pwrite;
    hit_clk = reg_hit(paddr, `BCX_OFF_CLK_CTL);
    hit_int = reg_hit(paddr, `BCX_OFF_INT_CTL);
    hit_status = reg_hit(paddr, `BCX_OFF_STATUS);
    hit_enable = reg_hit(paddr, `BCX_OFF_ENABLE);
    hit_clear = reg_hit(paddr, `BCX_OFF_CLEAR);
    hit_state = reg_hit(paddr, `BCX_OFF_STATE);
    mapped = hit_clk || hit_int || hit_status || hit_enable || hit_clear
             || hit_state;
  end

  // zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;

  // ------------------------------------------------------------
  // mode strap synchronisers
  // ------------------------------------------------------------
  logic [1:0] special_sync_q;
  logic [1:0] emul_sync_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      special_sync_q <= 2'h0;
      emul_sync_q <= 2'h0;
    end else begin
      special_sync_q <= {special_sync_q[0], mode_special_pin};
      emul_sync_q <= {emul_sync_q[0], mode_emulation_pin};
    end
  end

  bcx_mode_t mode;
  logic is_special;
  logic is_emulation;

  always_comb begin
    case ({emul_sync_q[1], special_sync_q[1]})
      2'b00: mode = BCX_MODE_NORMAL;
      2'b01: mode = BCX_MODE_SPECIAL;
      2'b10: mode = BCX_MODE_EMULATION;
      2'b11: mode = BCX_MODE_EMUL_SPECIAL;
      default: mode = BCX_MODE_NORMAL;
    endcase
  end

  always_comb begin
    case (mode)
      BCX_MODE_SPECIAL: begin
        is_special = 1'b1;
        is_emulation = 1'b0;
      end
      BCX_MODE_EMULATION: begin
        is_special = 1'b0;
        is_emulation = 1'b1;
      end
      BCX_MODE_EMUL_SPECIAL: begin
        is_special = 1'b1;
        is_emulation = 1'b1;
      end
      default: begin
        is_special = 1'b0;
        is_emulation = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // clock output control register
  // ------------------------------------------------------------
  logic x2_disable_q;
  bcx_div_t div_sel_q;
  localparam logic [7:0] RST_CLK = `BCX_RST_CLK_CTL;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      x2_disable_q <= RST_CLK[`BCX_X2_DIS_BIT];
      div_sel_q <= RST_CLK[`BCX_DIV_MSB:`BCX_DIV_LSB];
    end else if (wr && hit_clk) begin
      x2_disable_q <= pwdata[`BCX_X2_DIS_BIT];
      div_sel_q <= pwdata[`BCX_DIV_MSB:`BCX_DIV_LSB];
    end
  end

  // ------------------------------------------------------------
  // clock generator
  // ------------------------------------------------------------
  bcx_clk_if cif ();

  // emulation overrides the disable bit
  assign cif.x2_enable = is_emulation || !x2_disable_q;
  assign cif.div_sel = div_sel_q;
  assign cif.emulation = is_emulation;

  bcx_clk_gen u_clk_gen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cif(cif)
  );

  assign double_rate_clock_pin = cif.x2_pin;
  assign free_running_clock_pin = cif.free_pin;

  // ------------------------------------------------------------
  // external interrupt control register
  // ------------------------------------------------------------
  logic edge_select_q;
  logic connect_q;
  logic written_once_q;
  logic edge_write_ok;
  localparam logic [7:0] RST_INT = `BCX_RST_INT_CTL;

  // any write outside special mode counts toward the single allowed write
  assign edge_write_ok = is_special || !written_once_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      written_once_q <= 1'b0;
    end else if (wr && hit_int && !is_special) begin
      written_once_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      edge_select_q <= RST_INT[`BCX_EDGE_BIT];
    end else if (wr && hit_int && edge_write_ok) begin
      edge_select_q <= pwdata[`BCX_EDGE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      connect_q <= RST_INT[`BCX_CONNECT_BIT];
    end else if (wr && hit_int) begin
      connect_q <= pwdata[`BCX_CONNECT_BIT];
    end
  end

  // ------------------------------------------------------------
  // interrupt pin synchroniser and detection
  // ------------------------------------------------------------
  // resets high so a pin held low through reset is seen as a falling edge after release
  logic [1:0] pin_sync_q;
  logic pin_prev_q;
  logic pin_level;
  logic fall;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_sync_q <= 2'h3;
      pin_prev_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[0], ext_int_pin_n};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  assign pin_level = pin_sync_q[1];
  assign fall = pin_prev_q && !pin_level;

  logic edge_latch_q;
  logic edge_set;

  assign edge_set = edge_select_q && fall;

  // a new edge in the service cycle stays latched
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      edge_latch_q <= 1'b0;
    end else if (edge_set) begin
      edge_latch_q <= 1'b1;
    end else if (ext_int_ack) begin
      edge_latch_q <= 1'b0;
    end
  end

  logic req_raw;
  logic req_q;

  always_comb begin
    if (!connect_q) begin
      req_raw = 1'b0;
    end else if (edge_select_q) begin
      req_raw = edge_latch_q;
    end else begin
      req_raw = !pin_level;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_raw;
    end
  end

  assign ext_int_req = req_q;

  // ------------------------------------------------------------
  // event status, enable and clear
  // ------------------------------------------------------------
  logic [NEV-1:0] ev;
  logic [NEV-1:0] status_q;
  logic [NEV-1:0] enable_q;
  logic [NEV-1:0] clr;

  always_comb begin
    ev = '0;
    ev[`BCX_EV_EDGE] = edge_set;
    ev[`BCX_EV_REQ] = req_raw && !req_q;
    ev[`BCX_EV_REFUSED] = wr && hit_int && !edge_write_ok;
    clr = (wr && hit_clear) ? pwdata[NEV-1:0] : '0;
  end

  // set wins over a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < NEV; g++) begin : g_status
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          status_q[g] <= 1'b0;
        end else if (ev[g]) begin
          status_q[g] <= 1'b1;
        end else if (clr[g]) begin
          status_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= '0;
    end else if (wr && hit_enable) begin
      enable_q <= pwdata[NEV-1:0];
    end
  end

  logic irq_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q);
    end
  end

  assign irq = irq_q;

  // ------------------------------------------------------------
  // read data and error answer
  // ------------------------------------------------------------
  bcx_data_t rdata;

  always_comb begin
    rdata = '0;
    if (hit_clk) begin
      rdata[`BCX_X2_DIS_BIT] = x2_disable_q;
      rdata[`BCX_DIV_MSB:`BCX_DIV_LSB] = div_sel_q;
    end else if (hit_int) begin
      rdata[`BCX_EDGE_BIT] = edge_select_q;
      rdata[`BCX_CONNECT_BIT] = connect_q;
    end else if (hit_status) begin
      rdata[NEV-1:0] = status_q;
    end else if (hit_enable) begin
      rdata[NEV-1:0] = enable_q;
    end else if (hit_state) begin
      rdata[0] = pin_level;
      rdata[1] = edge_latch_q;
      rdata[2] = is_special;
      rdata[3] = is_emulation;
      rdata[4] = cif.x2_enable;
      rdata[5] = written_once_q;
    end
  end

  // clear register is write-only and reads as zero
  assign prdata = rd ? rdata : '0;
  assign pslverr = access && !mapped;
endmodule : bcx_top

// ==== verif/bcx_irq_src.sv ====
// external interrupt source driving the active-low request pin.
// assumes the bench asks for a level or a single falling edge.
module bcx_irq_src (
  input wire logic ref_clk,
  input wire logic hold_low,
  input wire logic fall_pulse,
  output logic pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] left_q = 2'h0;
  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // a pulse lasts three cycles: shorter ones may slip past the sync
  always @(posedge ref_clk) begin
    left_q <= fall_pulse ? 2'h3 : (left_q != 2'h0 ? left_q - 2'h1 : 2'h0);
  end
  // released pin is driven back high by the model
  assign pin_n = !(hold_low || left_q != 2'h0);
endmodule : bcx_irq_src

// ==== verif/bcx_top_chk.sv ====
// concurrent checks on the ports of bcx_top.
// assumes configuration reaches the block only through apb writes.
`include "bcx_regs.svh"
module bcx_top_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bcx_pkg::bcx_addr_t paddr,
  input wire bcx_pkg::bcx_data_t pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mode_special_pin,
  input wire logic mode_emulation_pin,
  input wire logic ext_int_pin_n,
  input wire logic ext_int_ack,
  input wire logic ext_int_req,
  input wire logic double_rate_clock_pin,
  input wire logic free_running_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import bcx_pkg::*;
  logic dis_q, conn_q, edge_q, once_q, wr_c, wr_i;
  logic [1:0] div_q;
  logic [5:0] age_q;
  logic [3:0] hi_q;
  assign wr_c = psel && penable && pwrite && paddr == `BCX_OFF_CLK_CTL;
  assign wr_i = psel && penable && pwrite && paddr == `BCX_OFF_INT_CTL;
  // ------------------------------------------------------------
  // shadow of the configuration
  // ------------------------------------------------------------
  // age gives outputs time to follow a new setting before judging them
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {dis_q, edge_q, once_q, div_q, age_q} <= '0;
      conn_q <= 1'b1;
    end else begin
      if (wr_c) begin
        dis_q <= pwdata[`BCX_X2_DIS_BIT];
        div_q <= pwdata[1:0];
      end
      if (wr_i) begin
        conn_q <= pwdata[`BCX_CONNECT_BIT];
        once_q <= once_q | !mode_special_pin;
        if (mode_special_pin || !once_q) edge_q <= pwdata[`BCX_EDGE_BIT];
      end
      age_q <= (wr_c || wr_i) ? 6'h0 : (age_q == 6'h3f ? age_q : age_q + 6'h1);
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hi_q <= 4'h0;
    else hi_q <= free_running_clock_pin ? hi_q + 4'h1 : 4'h0;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_pin_low; !ext_int_pin_n [*5]; endsequence
  property p_ready; pready; endproperty
  property p_slverr; psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > `BCX_OFF_STATE); endproperty
  property p_x2_run; (!dis_q || mode_emulation_pin) && age_q > 6'h7
    |=> double_rate_clock_pin != $past(double_rate_clock_pin); endproperty
  property p_x2_off; dis_q && !mode_emulation_pin && age_q > 6'h7
    |-> !double_rate_clock_pin; endproperty
  property p_free_len; $fell(free_running_clock_pin) && age_q > 6'h27
    |-> hi_q == (mode_emulation_pin ? 4'h2 : {1'b0, div_q, 1'b0} + 4'h2); endproperty
  property p_req_level; s_pin_low ##0 (!edge_q && conn_q && age_q > 6'h7)
    |-> ext_int_req; endproperty
  property p_req_disc; !conn_q && age_q > 6'h7 |-> !ext_int_req; endproperty
  property p_edge_hold; edge_q && conn_q && age_q > 6'h7 && ext_int_req && !ext_int_ack
    && !$past(ext_int_ack) |=> ext_int_req; endproperty
  a_ready: assert property (p_ready)
    else $error("pready low");
  a_slverr: assert property (p_slverr)
    else $error("slave error decode wrong");
  a_x2_run: assert property (p_x2_run)
    else $error("double rate clock not toggling");
  a_x2_off: assert property (p_x2_off)
    else $error("double rate clock not off");
  a_free_len: assert property (p_free_len)
    else $error("free clock high time wrong");
  a_req_level: assert property (p_req_level)
    else $error("no request on low level");
  a_req_disc: assert property (p_req_disc)
    else $error("request while disconnected");
  a_edge_hold: assert property (p_edge_hold)
    else $error("edge request dropped early");
endmodule : bcx_top_chk
bind bcx_top bcx_top_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .mode_special_pin(mode_special_pin),
  .mode_emulation_pin(mode_emulation_pin), .ext_int_pin_n(ext_int_pin_n),
  .ext_int_ack(ext_int_ack), .ext_int_req(ext_int_req),
  .double_rate_clock_pin(double_rate_clock_pin),
  .free_running_clock_pin(free_running_clock_pin));

// ==== verif/bus_clock_out_and_ext_irq_ctrl_bench.sv ====
// self-checking bench for bcx_top with an interrupt source model.
// assumes the checker is bound from its own file.
`include "bcx_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module bus_clock_out_and_ext_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bcx_pkg::*;
  logic ref_clk, resetn, psel, penable, pwrite, ext_int_ack, lvl, fall, pin_n;
  logic mode_special_pin, mode_emulation_pin, ready, err, se, req, dbl, free, irq;
  bcx_addr_t paddr;
  bcx_data_t pwdata, prdata, r;
  int failures, checks, fr, tg;
  bcx_top dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(ready),
    .pslverr(err), .mode_special_pin(mode_special_pin),
    .mode_emulation_pin(mode_emulation_pin), .ext_int_pin_n(pin_n),
    .ext_int_ack(ext_int_ack), .ext_int_req(req), .double_rate_clock_pin(dbl),
    .free_running_clock_pin(free), .irq(irq));
  bcx_irq_src src (.ref_clk(ref_clk), .hold_low(lvl), .fall_pulse(fall), .pin_n(pin_n));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // entered just after an edge; leaves one idle cycle so psel is never set twice at once
  task automatic apb(input logic w, input bcx_addr_t a, input bcx_data_t d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ready !== 1'b1);
    // zero wait states: the access ends in its first access cycle
    `CHK("wait", 1, n)
    r = prdata;
    se = err;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic cnt();
    logic pf, pd;
    fr = 0;
    tg = 0;
    pf = free;
    pd = dbl;
    repeat (48) begin
      @(posedge ref_clk);
      if (free === 1'b1 && pf === 1'b0) fr++;
      if (dbl !== pd) tg++;
      pf = free;
      pd = dbl;
    end
  endtask : cnt
  task automatic rst(input logic sp, input logic em);
    resetn <= 1'b0;
    mode_special_pin <= sp;
    mode_emulation_pin <= em;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : rst
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // the whole run needs well under 10 us
  initial begin
    #100us;
    failures++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, ext_int_ack, lvl, fall} = '0;
    {mode_special_pin, mode_emulation_pin, paddr, pwdata} = '0;
    rst(1'b0, 1'b0);
    apb(1'b0, `BCX_OFF_CLK_CTL, 32'h0);
    `CHK("clk_ctl", 32'h0, r)
    apb(1'b0, `BCX_OFF_INT_CTL, 32'h0);
    `CHK("int_ctl", 32'h40, r)
    apb(1'b0, 12'h018, 32'h0);
    `CHK("unmapped", 1'b1, se)
    apb(1'b1, `BCX_OFF_ENABLE, 32'h7);
    lvl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK("level_req", 1'b1, req)
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, `BCX_OFF_STATUS, 32'h0);
    `CHK("req_rose", 1'b1, r[1])
    lvl <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK("level_off", 1'b0, req)
    apb(1'b1, `BCX_OFF_CLEAR, 32'h7);
    repeat (3) @(posedge ref_clk);
    `CHK("irq_clr", 1'b0, irq)
    apb(1'b1, `BCX_OFF_INT_CTL, 32'h0);
    lvl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK("disc_req", 1'b0, req)
    lvl <= 1'b0;
    apb(1'b1, `BCX_OFF_INT_CTL, 32'hc0);
    apb(1'b0, `BCX_OFF_INT_CTL, 32'h0);
    `CHK("once", 32'h40, r)
    apb(1'b0, `BCX_OFF_STATUS, 32'h0);
    `CHK("refused", 1'b1, r[2])
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, `BCX_OFF_CLK_CTL, 32'(d));
      repeat (40) @(posedge ref_clk);
      cnt();
      `CHK("free_rises", 12 / (d + 1), fr)
      `CHK("x2_toggles", 48, tg)
    end
    apb(1'b1, `BCX_OFF_CLK_CTL, 32'h40);
    repeat (10) @(posedge ref_clk);
    cnt();
    `CHK("x2_off", 0, tg)
    rst(1'b1, 1'b0);
    apb(1'b1, `BCX_OFF_INT_CTL, 32'hc0);
    apb(1'b1, `BCX_OFF_INT_CTL, 32'h80);
    apb(1'b0, `BCX_OFF_INT_CTL, 32'h0);
    `CHK("special_wr", 32'h80, r)
    apb(1'b1, `BCX_OFF_INT_CTL, 32'hc0);
    fall <= 1'b1;
    @(posedge ref_clk);
    fall <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK("edge_req", 1'b1, req)
    repeat (20) @(posedge ref_clk);
    `CHK("edge_held", 1'b1, req)
    ext_int_ack <= 1'b1;
    @(posedge ref_clk);
    ext_int_ack <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("edge_ack", 1'b0, req)
    rst(1'b0, 1'b1);
    apb(1'b1, `BCX_OFF_CLK_CTL, 32'h43);
    repeat (40) @(posedge ref_clk);
    cnt();
    `CHK("emul_x2", 48, tg)
    `CHK("emul_free", 12, fr)
    rst(1'b1, 1'b1);
    apb(1'b1, `BCX_OFF_INT_CTL, 32'hc0);
    apb(1'b1, `BCX_OFF_INT_CTL, 32'h40);
    apb(1'b0, `BCX_OFF_INT_CTL, 32'h0);
    `CHK("emsp_wr", 32'h40, r)
    apb(1'b1, `BCX_OFF_CLK_CTL, 32'h40);
    apb(1'b0, `BCX_OFF_STATE, 32'h0);
    `CHK("emsp_state", 32'h1d, r)
    cnt();
    `CHK("emsp_x2", 48, tg)
    report_and_stop();
  end
endmodule : bus_clock_out_and_ext_irq_ctrl_bench
